// File: include/qqw_pkg.sv
// Package for the four-queue write-port admission block.
// Holds mode codes, port geometry and reset values shared by the design files other than the synchroniser.
package qqw_pkg;

    typedef enum logic [1:0] {
        QQW_MODE_MUX   = 2'b00,
        QQW_MODE_DEMUX = 2'b01,
        QQW_MODE_BCAST = 2'b10,
        QQW_MODE_RSVD  = 2'b11
    } qqw_mode_e;

    localparam int unsigned QQW_NUM_PORTS = 4;
    localparam int unsigned QQW_LANE_W = 10;
    localparam int unsigned QQW_BUS_W = 40;
    localparam int unsigned QQW_SYNC_STAGES = 2;

    localparam logic [1:0] QQW_MODE_RST = 2'h0;
    localparam logic QQW_DDR_RST = 1'b0;
    localparam logic QQW_READY_RST = 1'b0;
    localparam logic [3:0] QQW_MASK_ALL = 4'hf;
    localparam logic [3:0] QQW_MASK_NONE = 4'h0;

endpackage

// File: hw/qqw_sync.sv
// Two-flop level synchroniser, parameterised width.
// Assumes every bit is a quasi-static level or changes one bit at a time.
`timescale 1ns/1ps
`default_nettype none
module qqw_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    if (WIDTH == 0) begin : g_bad_width
        $error("WIDTH must be at least one");
    end

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end

    assign sync_out = sync_q;

endmodule
`default_nettype wire

// File: hw/qqw_cfg_capture.sv
// Reference-clock capture of the write configuration straps.
// Assumes master reset and straps are pins, asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module qqw_cfg_capture (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic wr_double_rate_sel,
    input wire logic [1:0] operating_mode_sel,
    output logic [1:0] mode_q,
    output logic ddr_q,
    output logic ready_q
);

    logic [3:0] pins_s;

    qqw_sync #(.WIDTH(4)) u_pin_sync (
        .clk(ref_clk),
        .async_in({master_reset_n, wr_double_rate_sel, operating_mode_sel}),
        .sync_out(pins_s)
    );

    // Straps are followed while master reset is low and frozen on release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_q <= qqw_pkg::QQW_MODE_RST;
            ddr_q <= qqw_pkg::QQW_DDR_RST;
        end else if (!pins_s[3]) begin
            mode_q <= pins_s[1:0]; // RULE9
            ddr_q <= pins_s[2]; // RULE9
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ready_q <= qqw_pkg::QQW_READY_RST;
        end else begin
            ready_q <= pins_s[3]; // RULE16
        end
    end

endmodule
`default_nettype wire

// File: hw/qqw_write_ports.sv
// Write-port admission for a four-queue flow-control buffer.
// Each write port runs on its own write clock; configuration is latched
// on ref_clk during master reset and passed to the ports as stable levels.
// Queue storage downstream consumes the per-port word strobes and masks.
//
// Contract
// RULE1: Mux mode: queue 0 written on clock 0.
// RULE2: Mux mode: queues 1-3 on their own clocks.
// RULE3: Demux/broadcast: all writes on clock 0.
// RULE4: Demux/broadcast: clocks 1-3 ignored.
// RULE5: Mux queue 0 needs enable and select low.
// RULE6: Demux/broadcast port needs enable and select low.
// RULE7: Mux queues 1-3 need own enable, select low.
// RULE8: Demux/broadcast: enables 1-3 ignored.
// RULE9: Rate and mode latched during master reset.
// RULE10: Double rate: word on both clock edges.
// RULE11: Single rate: word on rising edge only.
// RULE12: Chip select sampled on rising edge only.
// RULE13: Producer holds straps stable around reset.
// RULE14: Input select steers only in demux mode.
// RULE15: Broadcast writes all queues; demux one queue.
// RULE16: No writes while master reset active.
`timescale 1ns/1ps
`default_nettype none
module qqw_write_ports #(
    parameter int unsigned BUS_W = qqw_pkg::QQW_BUS_W,
    parameter int unsigned LANE_W = qqw_pkg::QQW_LANE_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic wr_double_rate_sel,
    input wire logic [1:0] operating_mode_sel,
    input wire logic wr_clock_port0,
    input wire logic wr_clock_port1,
    input wire logic wr_clock_port2,
    input wire logic wr_clock_port3,
    input wire logic wr_enable_n_port0,
    input wire logic wr_enable_n_port1,
    input wire logic wr_enable_n_port2,
    input wire logic wr_enable_n_port3,
    input wire logic wr_select_n_port0,
    input wire logic wr_select_n_port1,
    input wire logic wr_select_n_port2,
    input wire logic wr_select_n_port3,
    input wire logic [1:0] target_queue_sel,
    input wire logic [BUS_W-1:0] wr_data,
    output wire logic [3:0] word_lo_valid,
    output wire logic [3:0] word_hi_valid,
    output wire logic [2*BUS_W-1:0] word_data [4],
    output wire logic [3:0] word_queue_mask [4],
    output logic [1:0] cfg_mode,
    output logic cfg_double_rate,
    output logic cfg_ready
);

    localparam int unsigned NP = qqw_pkg::QQW_NUM_PORTS;

    if (LANE_W * NP != BUS_W) begin : g_bad_width
        $error("BUS_W must equal four lanes of LANE_W");
    end

    // Decoding of the target queue, used for routing and mux identity
    function automatic logic [3:0] qqw_onehot(input logic [1:0] idx);
        logic [3:0] r;
        r = qqw_pkg::QQW_MASK_NONE;
        r[idx] = 1'b1;
        return r;
    endfunction

    logic [NP-1:0] wclk;
    logic [NP-1:0] wen_n;
    logic [NP-1:0] wcs_n;

    assign wclk = {wr_clock_port3, wr_clock_port2, wr_clock_port1, wr_clock_port0};
    assign wen_n = {wr_enable_n_port3, wr_enable_n_port2, wr_enable_n_port1,
                    wr_enable_n_port0};
    assign wcs_n = {wr_select_n_port3, wr_select_n_port2, wr_select_n_port1,
                    wr_select_n_port0};

    // Straps are captured on ref_clk; the producer keeps them steady
    // around master reset, so the ports see quasi-static levels.
    qqw_cfg_capture u_cfg ( // RULE13
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .master_reset_n(master_reset_n),
        .wr_double_rate_sel(wr_double_rate_sel),
        .operating_mode_sel(operating_mode_sel),
        .mode_q(cfg_mode),
        .ddr_q(cfg_double_rate),
        .ready_q(cfg_ready)
    );

    for (genvar p = 0; p < NP; p++) begin : g_port
        logic [3:0] cfg_s;
        logic rdy;
        logic ddr;
        qqw_pkg::qqw_mode_e mode;
        logic port_on;
        logic [BUS_W-1:0] din;
        logic [3:0] mask_d;

        logic cs_rise_q;
        logic r_acc_q;
        logic [BUS_W-1:0] r_data_q;
        logic [3:0] r_mask_q;
        logic f_acc_q;
        logic [BUS_W-1:0] f_data_q;
        logic lo_q;
        logic hi_q;
        logic [2*BUS_W-1:0] data_q;
        logic [3:0] mask_q;

        // Ready changes only while writes are blocked; mode and rate are
        // stable whenever ready is high, so a plain level sync suffices.
        qqw_sync #(.WIDTH(4)) u_cfg_sync (
            .clk(wclk[p]),
            .async_in({cfg_ready, cfg_double_rate, cfg_mode}),
            .sync_out(cfg_s)
        );

        assign rdy = cfg_s[3];
        assign ddr = cfg_s[2];
        assign mode = qqw_pkg::qqw_mode_e'(cfg_s[1:0]);

        // Ports 1-3 act in mux and reserved modes; in demux/broadcast their pins are ignored
        if (p == 0) begin : g_p0
            assign port_on = 1'b1; // RULE3
            assign din = (mode == qqw_pkg::QQW_MODE_DEMUX ||
                          mode == qqw_pkg::QQW_MODE_BCAST) ?
                         wr_data :
                         {{(BUS_W-LANE_W){1'b0}}, wr_data[LANE_W-1:0]};
        end else begin : g_pn
            assign port_on = (mode != qqw_pkg::QQW_MODE_DEMUX) &&
                             (mode != qqw_pkg::QQW_MODE_BCAST); // RULE4 RULE8
            assign din = {{(BUS_W-LANE_W){1'b0}}, wr_data[p*LANE_W +: LANE_W]};
        end

        always_comb begin
            unique case (mode)
                qqw_pkg::QQW_MODE_DEMUX: mask_d = qqw_onehot(target_queue_sel); // RULE14
                qqw_pkg::QQW_MODE_BCAST: mask_d = qqw_pkg::QQW_MASK_ALL; // RULE15
                qqw_pkg::QQW_MODE_MUX: mask_d = qqw_onehot(2'(p)); // RULE1 RULE2
                qqw_pkg::QQW_MODE_RSVD: mask_d = qqw_onehot(2'(p));
            endcase
        end

        // Rising edge: select and enable sampled, first word of the pair
        always_ff @(posedge wclk[p]) begin
            if (!rdy) begin
                cs_rise_q <= 1'b0;
                r_acc_q <= 1'b0;
                r_mask_q <= qqw_pkg::QQW_MASK_NONE;
            end else begin
                cs_rise_q <= !wcs_n[p] && port_on; // RULE12
                r_acc_q <= port_on && !wen_n[p] && !wcs_n[p]; // RULE5 RULE6 RULE7 RULE11
                r_mask_q <= mask_d;
            end
        end

        always_ff @(posedge wclk[p]) begin
            r_data_q <= din;
        end

        // Falling edge: second word, select held from the rising edge
        always_ff @(negedge wclk[p]) begin
            if (!rdy) begin
                f_acc_q <= 1'b0;
            end else begin
                f_acc_q <= ddr && cs_rise_q && !wen_n[p]; // RULE10 RULE12 RULE16
            end
        end

        always_ff @(negedge wclk[p]) begin
            f_data_q <= din;
        end

        // One internal word per clock period: rise word low, fall word high
        always_ff @(posedge wclk[p]) begin
            if (!rdy) begin
                lo_q <= 1'b0;
                hi_q <= 1'b0;
                mask_q <= qqw_pkg::QQW_MASK_NONE;
            end else begin
                lo_q <= r_acc_q; // RULE16
                hi_q <= f_acc_q && ddr; // RULE11
                mask_q <= r_mask_q;
            end
        end

        always_ff @(posedge wclk[p]) begin
            data_q <= {f_data_q, r_data_q};
        end

        assign word_lo_valid[p] = lo_q;
        assign word_hi_valid[p] = hi_q;
        assign word_data[p] = data_q;
        assign word_queue_mask[p] = mask_q;
    end

endmodule
`default_nettype wire

// File: verif/qqw_write_ports_properties.sv
// Checker for the write-port admission block.
// Sees only top-level ports; bound into every qqw_write_ports instance.
`timescale 1ns/1ps
`default_nettype none
module qqw_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic wr_clock_port0,
    input wire logic wr_clock_port1,
    input wire logic wr_clock_port2,
    input wire logic wr_enable_n_port0,
    input wire logic wr_enable_n_port1,
    input wire logic wr_select_n_port0,
    input wire logic wr_select_n_port1,
    input wire logic [1:0] target_queue_sel,
    input wire logic [3:0] word_lo_valid,
    input wire logic [3:0] word_hi_valid,
    input wire logic [3:0] word_queue_mask [4],
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_double_rate,
    input wire logic cfg_ready
);
    // A word taken at one rising edge shows its valid after the next one,
    // so the cause lies two samples back
    a_lo0_needs_en: assert property (@(posedge wr_clock_port0)
        disable iff (!cfg_ready)
        word_lo_valid[0] |-> !$past(wr_enable_n_port0, 2) && !$past(wr_select_n_port0, 2))
        else $error("lo0 cause");
    a_lo1_mux_only: assert property (@(posedge wr_clock_port1)
        disable iff (!cfg_ready)
        word_lo_valid[1] |-> !$past(wr_enable_n_port1, 2) && !$past(wr_select_n_port1, 2) &&
        cfg_mode[1:0] inside {2'h0, 2'h3})
        else $error("lo1 cause");
    a_lo0_taken: assert property (@(posedge wr_clock_port0)
        disable iff (!cfg_ready)
        $past(cfg_ready, 4) && !wr_enable_n_port0 && !wr_select_n_port0 |-> ##2 word_lo_valid[0])
        else $error("lo0 missed");
    a_sdr_no_hi: assert property (@(posedge wr_clock_port0) disable iff (!cfg_ready)
        !cfg_double_rate |-> !word_hi_valid[0]) else $error("hi in sdr");
    a_hi_sel_rise: assert property (@(posedge wr_clock_port0) disable iff (!cfg_ready)
        word_hi_valid[0] |-> !$past(wr_select_n_port0, 2) && cfg_double_rate) else $error("hi cause");
    a_bcast_all: assert property (@(posedge wr_clock_port0) disable iff (!cfg_ready)
        word_lo_valid[0] && cfg_mode == 2'h2 |-> word_queue_mask[0] == 4'hf) else $error("bcast mask");
    a_demux_steer: assert property (@(posedge wr_clock_port0)
        disable iff (!cfg_ready)
        word_lo_valid[0] && cfg_mode == 2'h1 |->
        word_queue_mask[0] == (4'h1 << $past(target_queue_sel, 2)))
        else $error("demux mask");
    a_mux_port2: assert property (@(posedge wr_clock_port2) disable iff (!cfg_ready)
        word_lo_valid[2] |-> word_queue_mask[2] == 4'h4) else $error("port2 mask");
    a_mrs_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !master_reset_n [*4] |-> !cfg_ready) else $error("ready in reset");
    a_cfg_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_ready && $past(cfg_ready) |-> $stable(cfg_mode) && $stable(cfg_double_rate))
        else $error("cfg moved");
    c_ddr: cover property (@(posedge wr_clock_port0) word_hi_valid[0]);
    c_mux2: cover property (@(posedge wr_clock_port2) word_lo_valid[2]);
    c_bcast: cover property (@(posedge wr_clock_port0) word_lo_valid[0] && cfg_mode == 2'h2);
endmodule
bind qqw_write_ports qqw_props u_props (.ref_clk, .rst_n, .master_reset_n, .wr_clock_port0,
    .wr_clock_port1, .wr_clock_port2, .wr_enable_n_port0, .wr_enable_n_port1, .wr_select_n_port0,
    .wr_select_n_port1, .target_queue_sel, .word_lo_valid, .word_hi_valid, .word_queue_mask,
    .cfg_mode, .cfg_double_rate, .cfg_ready);
`default_nettype wire

// File: verif/qqw_producer.sv
// Upstream producer: four free-running write clocks and a one-word task.
// Assumes the bench owns straps and target select.
`timescale 1ns/1ps
`default_nettype none
module qqw_producer (
    output logic [3:0] wclk,
    output logic [3:0] wen_n,
    output logic [3:0] wcs_n,
    output logic [39:0] data
);
    initial begin
        wclk = 4'h0;
        wen_n = 4'hf;
        wcs_n = 4'hf;
        data = 40'h0;
    end
    for (genvar i = 0; i < 4; i++) begin : g_clk
        initial begin
            #(7 + 11 * i);
            forever #40 wclk[i] = ~wclk[i];
        end
    end
    // Idle bus shows the inverse so stale data cannot match by chance
    task automatic word(input int p, input logic [39:0] a, input logic [39:0] b,
                        input logic en_n, input logic cs_n);
        @(negedge wclk[p]);
        #5;
        data = a;
        wen_n[p] = en_n;
        wcs_n[p] = cs_n;
        @(posedge wclk[p]);
        #5;
        data = b;
        wcs_n[p] = ~cs_n;
        @(negedge wclk[p]);
        #5;
        wen_n[p] = 1'b1;
        wcs_n[p] = 1'b1;
        data = ~b;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the write-port admission block.
// Producer model drives the write side; bench drives straps and resets.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [39:0] D = 40'h12345_6789a;
    logic ref_clk, rst_n, mrst_n, ddr;
    logic [1:0] mode, sel;
    wire [3:0] wclk, wen_n, wcs_n, lo, hi;
    wire [39:0] data;
    wire [79:0] wd [4];
    wire [3:0] wm [4];
    wire [1:0] cm;
    wire cd, cr;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    qqw_producer prod (.wclk(wclk), .wen_n(wen_n), .wcs_n(wcs_n), .data(data));
    qqw_write_ports DUT (.ref_clk(ref_clk), .rst_n(rst_n), .master_reset_n(mrst_n),
        .wr_double_rate_sel(ddr), .operating_mode_sel(mode), .wr_clock_port0(wclk[0]),
        .wr_clock_port1(wclk[1]), .wr_clock_port2(wclk[2]), .wr_clock_port3(wclk[3]),
        .wr_enable_n_port0(wen_n[0]), .wr_enable_n_port1(wen_n[1]), .wr_enable_n_port2(wen_n[2]),
        .wr_enable_n_port3(wen_n[3]), .wr_select_n_port0(wcs_n[0]), .wr_select_n_port1(wcs_n[1]),
        .wr_select_n_port2(wcs_n[2]), .wr_select_n_port3(wcs_n[3]), .target_queue_sel(sel),
        .wr_data(data), .word_lo_valid(lo), .word_hi_valid(hi), .word_data(wd),
        .word_queue_mask(wm), .cfg_mode(cm), .cfg_double_rate(cd), .cfg_ready(cr));
    task automatic tally_and_finish();
        $display("tests=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic setup(input logic [1:0] m, input logic d);
        #2;
        mrst_n = 1'b0;
        mode = m;
        ddr = d;
        repeat (8) @(posedge ref_clk);
        prod.word(0, D, D, 1'b0, 1'b0);
        @(posedge wclk[0]);
        #1;
        chk(lo[0], 1'b0);
        @(posedge ref_clk);
        #2;
        mrst_n = 1'b1;
        repeat (5) @(posedge ref_clk);
        #2;
        mode = ~m;
        ddr = ~d;
        repeat (8) @(posedge ref_clk);
        chk({cr, cd, cm}, {1'b1, d, m});
    endtask
    // Fall half only exists in double rate, so single-rate checks look at the rise half
    task automatic put(input int p, input logic [39:0] b, input logic [79:0] ed,
                       input logic [3:0] em, input logic [1:0] ev);
        prod.word(p, D, b, 1'b0, 1'b0);
        @(posedge wclk[p]);
        #1;
        chk({lo[p], hi[p]}, ev);
        chk(ev[0] ? wd[p] : wd[p][39:0], ed);
        chk(wm[p], em);
    endtask
    task automatic t_mux();
        setup(qqw_pkg::QQW_MODE_MUX, 1'b0);
        for (int p = 0; p < 4; p++) begin
            put(p, D, (D >> (10 * p)) & 40'h3ff, 4'h1 << p, 2'b10);
        end
        prod.word(1, D, D, 1'b0, 1'b1);
        @(posedge wclk[1]);
        #1;
        chk(lo[1], 1'b0);
        $display("mux test done");
    endtask
    task automatic t_demux();
        setup(qqw_pkg::QQW_MODE_DEMUX, 1'b1);
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            put(0, ~D, {~D, D}, 4'h1 << s, 2'b11);
        end
        prod.word(1, D, D, 1'b0, 1'b0);
        @(posedge wclk[1]);
        #1;
        chk(lo[1], 1'b0);
        prod.word(0, D, D, 1'b1, 1'b0);
        @(posedge wclk[0]);
        #1;
        chk(lo[0], 1'b0);
        $display("demux test done");
    endtask
    task automatic t_bcast();
        setup(qqw_pkg::QQW_MODE_BCAST, 1'b0);
        sel = 2'h1;
        put(0, D, D, 4'hf, 2'b10);
        $display("broadcast test done");
    endtask
    // Code 11 behaves as mux; double rate on a lane port pairs two lane words
    task automatic t_rsvd();
        setup(2'h3, 1'b1);
        put(2, ~D, {(~D >> 20) & 40'h3ff, (D >> 20) & 40'h3ff}, 4'h4, 2'b11);
        $display("reserved mode test done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        rst_n = 1'b0;
        mrst_n = 1'b0;
        mode = 2'h0;
        ddr = 1'b0;
        sel = 2'h0;
        repeat (20) @(posedge ref_clk);
        #2;
        rst_n = 1'b1;
        t_mux();
        t_demux();
        t_bcast();
        t_rsvd();
        tally_and_finish();
    end
endmodule
`default_nettype wire
